// ==== logic/dsc_pkg.sv ====
// constants, types and register map of the drive startup configuration loader
package dsc_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned HALL_HOLD_MS = 1000;
    localparam int unsigned HALL_HOLD_CYC = (CLK_HZ / 1000) * HALL_HOLD_MS;
    localparam int unsigned BLINK_MS = 100;
    localparam int unsigned BLINK_CYC = (CLK_HZ / 1000) * BLINK_MS;
    localparam logic [15:0] NV_AUTORUN_ADDR = 16'h2000;
    localparam logic [15:0] NV_AUTORUN_OFF = 16'h0001;
    localparam logic [7:0] ID_DEFAULT = 8'hFF;
    localparam logic [7:0] ID_BASE = 8'h01;
    localparam logic [15:0] ALIAS_NONE = 16'h0000;
    localparam int unsigned MERR_SETUP_BIT = 2;
    localparam int unsigned RESET_STORM_CNT = 3;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SWID = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_NODE = 8'h0C;
    localparam logic [7:0] ADDR_ALIAS = 8'h10;
    localparam logic [7:0] ADDR_MERR = 8'h14;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h1C;
    localparam logic [7:0] ADDR_NV_WADDR = 8'h20;
    localparam logic [7:0] ADDR_NV_WDATA = 8'h24;
    // control bits
    localparam int unsigned CTRL_HW_ID = 0;
    localparam int unsigned CTRL_ETH_VAR = 1;
    localparam int unsigned CTRL_NODE_ADDR = 2;
    localparam int unsigned CTRL_PROG_VALID = 3;
    localparam int unsigned CTRL_SETUP_VALID = 4;
    // interrupt bits
    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_CONFIG_DONE = 0;
    localparam int unsigned IRQ_AUTORUN = 1;
    localparam int unsigned IRQ_SETUP_INV = 2;
    localparam int unsigned IRQ_RESET_STORM = 3;

    typedef enum logic [2:0] {
        DSC_SAMPLE = 3'b000,
        DSC_HALL_WAIT = 3'b001,
        DSC_DECIDE = 3'b010,
        DSC_WAIT_MOT = 3'b011,
        DSC_RUN = 3'b100,
        DSC_SLAVE = 3'b101
    } dsc_state_t;
endpackage

// ==== logic/dsc_id_calc.sv ====
// switch code to node identifier arithmetic
module dsc_id_calc
    import dsc_pkg::*;
(
    // switch inputs
    input wire logic [3:0] bank_i,
    input wire logic msb_i,
    input wire logic eth_i,
    input wire logic [1:0] axis_pos_i,
    // result
    output logic [7:0] id_o
);
    logic [4:0] code;
    always_comb begin
        code = {eth_i & msb_i, bank_i};
        id_o = ID_BASE + {code, 3'b000} + {6'b0, axis_pos_i};
    end
endmodule

// ==== logic/dsc_blink.sv ====
// fault blink generator for the ready and error indicators
module dsc_blink
    import dsc_pkg::*;
#(
    parameter int unsigned PERIOD = BLINK_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic en_i,
    output logic on_o
);
    typedef struct packed {
        logic [31:0] cnt;
        logic on;
    } dsc_blink_t;
    dsc_blink_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        if (!en_i) begin
            s_d.cnt = '0;
            s_d.on = 1'b0;
        end else if (s_q.cnt >= PERIOD - 1) begin
            s_d.cnt = '0;
            s_d.on = ~s_q.on;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) s_q <= '0;
        else s_q <= s_d;
    end
    assign on_o = s_q.on;
endmodule

// ==== logic/dsc_top.sv ====
// drive startup configuration loader with wishbone registers
//
// Added by the designer: the register offsets and the Wishbone register port.
module dsc_top
    import dsc_pkg::*;
#(
    parameter int unsigned HALL_CYC = HALL_HOLD_CYC,
    parameter int unsigned BLINK_PER = BLINK_CYC,
    parameter int unsigned HALL_W = 3
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // switches and sensors
    input wire logic [3:0] node_id_switch_bank_i,
    input wire logic protocol_or_id_msb_switch_i,
    input wire logic [1:0] axis_pos_i,
    input wire logic [HALL_W-1:0] hall_i,
    input wire logic motor_supply_ok_i,
    input wire logic setup_corrupt_i,
    // status outputs
    output logic [7:0] node_identifier_o,
    output logic vendor_can_protocol_mode_o,
    output logic lss_inactive_o,
    output logic [15:0] station_alias_o,
    output logic program_start_o,
    output logic slave_mode_o,
    output logic ready_led_o,
    output logic error_led_o,
    output logic irq_o
);
    typedef struct packed {
        dsc_state_t st;
        logic [3:0] bank;
        logic msb;
        logic [7:0] sw_id;
        logic [4:0] ctrl;
        logic [7:0] node;
        logic [15:0] alias_val;
        logic vendor;
        logic lss_off;
        logic setup_inv;
        logic prog_ok;
        logic start;
        logic slave;
        logic [31:0] hall_cnt;
        logic [1:0] storm;
        logic [15:0] merr;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_msk;
        logic [15:0] nv_addr;
        logic ack;
        logic [31:0] rdat;
    } dsc_state_s_t;

    dsc_state_s_t s_q, s_d;
    logic [7:0] hw_id;
    logic blink;

    dsc_id_calc u_id (
        .bank_i(s_q.bank),
        .msb_i(s_q.msb),
        .eth_i(s_q.ctrl[CTRL_ETH_VAR]),
        .axis_pos_i(axis_pos_i),
        .id_o(hw_id)
    );

    dsc_blink #(.PERIOD(BLINK_PER)) u_blink (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(s_q.storm == RESET_STORM_CNT[1:0]),
        .on_o(blink)
    );

    function automatic logic [31:0] wmask(input logic [3:0] sel);
        wmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    logic req;
    logic [31:0] wm;
    logic [31:0] wd;
    logic [IRQ_W-1:0] ev;
    logic [7:0] chosen;
    logic sw_id_ok;

    always_comb begin
        s_d = s_q;
        ev = '0;
        req = wb_cyc_i & wb_stb_i & ~s_q.ack;
        wm = wmask(wb_sel_i);
        wd = wb_dat_i & wm;
        sw_id_ok = (s_q.sw_id != 8'h00);
        chosen = (s_q.ctrl[CTRL_HW_ID] || s_q.setup_inv) ? hw_id : (sw_id_ok ? s_q.sw_id : ID_DEFAULT);
        s_d.start = 1'b0;
        case (s_q.st)
            DSC_SAMPLE: begin
                // one-shot capture of bank and msb; axis_pos_i is still read live until DSC_DECIDE latches the node
                s_d.bank = node_id_switch_bank_i;
                s_d.msb = protocol_or_id_msb_switch_i;
                s_d.hall_cnt = '0;
                s_d.st = DSC_HALL_WAIT;
            end
            DSC_HALL_WAIT: begin
                if (hall_i != '0) begin
                    s_d.st = DSC_DECIDE;
                end else if (s_q.hall_cnt >= HALL_CYC - 1) begin
                    s_d.setup_inv = 1'b1;
                    s_d.merr[MERR_SETUP_BIT] = 1'b1;
                    ev[IRQ_SETUP_INV] = 1'b1;
                    s_d.slave = 1'b1;
                    s_d.st = DSC_DECIDE;
                end else begin
                    s_d.hall_cnt = s_q.hall_cnt + 32'h1;
                end
            end
            DSC_DECIDE: begin
                if (!s_q.ctrl[CTRL_SETUP_VALID]) begin
                    s_d.setup_inv = 1'b1;
                    s_d.merr[MERR_SETUP_BIT] = 1'b1;
                end
                s_d.node = chosen;
                s_d.vendor = ~s_q.ctrl[CTRL_ETH_VAR] & s_q.msb;
                s_d.lss_off = ~s_q.ctrl[CTRL_ETH_VAR] & ~s_q.msb & (chosen == ID_DEFAULT);
                if (s_q.ctrl[CTRL_ETH_VAR] && s_q.ctrl[CTRL_NODE_ADDR]) begin
                    s_d.alias_val = (chosen == ID_DEFAULT) ? ALIAS_NONE : {8'h00, chosen};
                end
                s_d.prog_ok = s_q.prog_ok & s_q.ctrl[CTRL_PROG_VALID];
                ev[IRQ_CONFIG_DONE] = 1'b1;
                if (s_q.slave || !s_d.prog_ok || !s_d.vendor) begin
                    s_d.slave = 1'b1;
                    s_d.st = DSC_SLAVE;
                end else begin
                    s_d.st = DSC_WAIT_MOT;
                end
            end
            DSC_WAIT_MOT: begin
                if (!s_q.prog_ok) begin
                    s_d.slave = 1'b1;
                    s_d.st = DSC_SLAVE;
                end else if (motor_supply_ok_i) begin
                    s_d.start = 1'b1;
                    ev[IRQ_AUTORUN] = 1'b1;
                    s_d.st = DSC_RUN;
                end
            end
            DSC_RUN: s_d.st = DSC_RUN;
            DSC_SLAVE: s_d.st = DSC_SLAVE;
            default: s_d.st = DSC_SAMPLE;
        endcase
        // repeated corrupt-table resets drive the twin blink
        if (setup_corrupt_i && s_q.storm != RESET_STORM_CNT[1:0]) begin
            s_d.storm = s_q.storm + 2'h1;
        end
        if (setup_corrupt_i) ev[IRQ_RESET_STORM] = 1'b1;
        s_d.ack = req;
        if (req && wb_we_i) begin
            case (wb_adr_i)
                ADDR_CTRL: s_d.ctrl = (s_q.ctrl & ~wm[4:0]) | wd[4:0];
                ADDR_SWID: s_d.sw_id = (s_q.sw_id & ~wm[7:0]) | wd[7:0];
                // a bit raised in this very cycle survives the clear
                ADDR_MERR: s_d.merr = (s_q.merr & ~wd[15:0]) | (s_d.merr & ~s_q.merr);
                ADDR_IRQ_MSK: s_d.irq_msk = (s_q.irq_msk & ~wm[IRQ_W-1:0]) | wd[IRQ_W-1:0];
                ADDR_IRQ_ST: s_d.irq_st = s_q.irq_st & ~wd[IRQ_W-1:0];
                ADDR_NV_WADDR: s_d.nv_addr = (s_q.nv_addr & ~wm[15:0]) | wd[15:0];
                ADDR_NV_WDATA: begin
                    if (s_q.nv_addr == NV_AUTORUN_ADDR && wd[15:0] == NV_AUTORUN_OFF && wm[15:0] == 16'hFFFF) begin
                        s_d.prog_ok = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // set wins over clear
        s_d.irq_st = s_d.irq_st | ev;
        s_d.rdat = '0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                ADDR_CTRL: s_d.rdat = {27'h0, s_q.ctrl};
                ADDR_SWID: s_d.rdat = {24'h0, s_q.sw_id};
                ADDR_STAT: s_d.rdat = {23'h0, s_q.storm, s_q.prog_ok, s_q.setup_inv, s_q.slave, s_q.st, s_q.msb};
                ADDR_NODE: s_d.rdat = {18'h0, s_q.bank, s_q.lss_off, s_q.vendor, s_q.node};
                ADDR_ALIAS: s_d.rdat = {16'h0, s_q.alias_val};
                ADDR_MERR: s_d.rdat = {16'h0, s_q.merr};
                ADDR_IRQ_ST: s_d.rdat = {28'h0, s_q.irq_st};
                ADDR_IRQ_MSK: s_d.rdat = {28'h0, s_q.irq_msk};
                ADDR_NV_WADDR: s_d.rdat = {16'h0, s_q.nv_addr};
                default: s_d.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= DSC_SAMPLE;
            s_q.sw_id <= ID_DEFAULT;
            s_q.node <= ID_DEFAULT;
            s_q.ctrl <= 5'((1 << CTRL_PROG_VALID) | (1 << CTRL_SETUP_VALID));
            s_q.prog_ok <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.rdat;
    assign wb_ack_o = s_q.ack;
    assign node_identifier_o = s_q.node;
    assign vendor_can_protocol_mode_o = s_q.vendor;
    assign lss_inactive_o = s_q.lss_off;
    assign station_alias_o = s_q.alias_val;
    assign program_start_o = s_q.start;
    assign slave_mode_o = s_q.slave;
    assign ready_led_o = blink;
    assign error_led_o = blink;
    assign irq_o = |(s_q.irq_st & s_q.irq_msk);
endmodule

// ==== bench/dsc_checker.sv ====
// port assertions of the startup configuration loader
module dsc_checker
    import dsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [7:0] node_identifier_o,
    input wire logic vendor_can_protocol_mode_o,
    input wire logic lss_inactive_o,
    input wire logic [15:0] station_alias_o,
    input wire logic program_start_o,
    input wire logic slave_mode_o,
    input wire logic motor_supply_ok_i,
    input wire logic ready_led_o,
    input wire logic error_led_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_start_pulse: assert property (program_start_o |=> !program_start_o)
        else $error("start longer than one cycle");
    a_start_vendor_only: assert property (program_start_o |-> vendor_can_protocol_mode_o && !slave_mode_o)
        else $error("start outside vendor mode");
    a_start_supply: assert property (program_start_o |-> $past(motor_supply_ok_i))
        else $error("start without motor supply");
    a_leds_together: assert property (ready_led_o == error_led_o)
        else $error("indicators differ");
    a_blink_hold: assert property ($changed(ready_led_o) |=> $stable(ready_led_o))
        else $error("indicator flicker");
    a_lss_default: assert property (lss_inactive_o |-> node_identifier_o == ID_DEFAULT && !vendor_can_protocol_mode_o)
        else $error("lss inactive with wrong id");
    a_alias_node: assert property (station_alias_o != ALIAS_NONE |->
        station_alias_o == {8'h00, node_identifier_o} && node_identifier_o != ID_DEFAULT)
        else $error("alias not node id");
    a_id_latched: assert property ($changed(node_identifier_o) |=> $stable(node_identifier_o) [*8])
        else $error("node id moved");
endmodule

// ==== bench/dsc_bus_master.sv ====
// fieldbus master model reaching the drive registers over classic wishbone
module dsc_bus_master (
    // clock
    input wire logic clk_i,
    // answer
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i,
    // request
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int bus_err = 0;
    initial begin
        {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
    end
    // one request at a time, always with all four byte lanes selected
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= 4'hF;
        wb_dat_o <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 100);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        if (n >= 100) begin
            bus_err = 1;
            dsc_tb_top.conclude();
        end
    endtask
endmodule

// ==== bench/dsc_tb_top.sv ====
// self-checking testbench of the startup configuration loader
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end
module dsc_tb_top
    import dsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, msb = 0, supply = 0, corrupt = 0;
    logic [3:0] bank = '0, wb_sel;
    logic [1:0] axis = '0;
    logic [2:0] hall = '0;
    logic wb_cyc, wb_stb, wb_we, wb_ack, irq, start, slave, vend, lss, rdy, err;
    logic [7:0] wb_adr, node;
    logic [31:0] wb_wd, wb_rd, q;
    logic [15:0] alias_w;
    int error_cnt = 0, compares = 0, starts = 0, n;
    always #12.5 clk_i = ~clk_i;
    // short hall hold and blink period keep the run brief
    dsc_top #(.HALL_CYC(40), .BLINK_PER(4), .HALL_W(3)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
        .node_id_switch_bank_i(bank), .protocol_or_id_msb_switch_i(msb), .axis_pos_i(axis), .hall_i(hall),
        .motor_supply_ok_i(supply), .setup_corrupt_i(corrupt), .node_identifier_o(node),
        .vendor_can_protocol_mode_o(vend), .lss_inactive_o(lss), .station_alias_o(alias_w),
        .program_start_o(start), .slave_mode_o(slave), .ready_led_o(rdy), .error_led_o(err), .irq_o(irq));
    dsc_bus_master bus (.clk_i(clk_i), .wb_ack_i(wb_ack), .wb_dat_i(wb_rd), .wb_cyc_o(wb_cyc),
        .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wd));
    always @(posedge clk_i) if (start === 1'b1) starts <= starts + 1;
    function automatic logic [7:0] exp_id(input logic e, m, input logic [3:0] b, input logic [1:0] a);
        return 8'h01 + {e & m, b, 3'h0} + {6'h00, a};
    endfunction
    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic conclude();
        error_cnt += bus.bus_err;
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // power cycle: registers must be set while the hall phase still runs
    task automatic boot(input logic [3:0] b, input logic m, input logic [1:0] a, input logic [31:0] ctl, sw,
                        input bit hold, nv);
        @(posedge clk_i);
        bank <= b; msb <= m; axis <= a; hall <= '0; supply <= 1'b0; rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        starts = 0;
        bus.xfer(1'b1, ADDR_CTRL, ctl, q);
        bus.xfer(1'b1, ADDR_SWID, sw, q);
        bus.xfer(1'b1, ADDR_IRQ_MSK, 32'h1, q);
        if (nv) bus.xfer(1'b1, ADDR_NV_WADDR, {16'h0, NV_AUTORUN_ADDR}, q);
        if (nv) bus.xfer(1'b1, ADDR_NV_WDATA, {16'h0, NV_AUTORUN_OFF}, q);
        if (!hold) hall <= 3'h5;
        n = 0;
        while (irq !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 300) begin
            error_cnt++;
            conclude();
        end
        supply <= 1'b1;
        bus.xfer(1'b1, ADDR_IRQ_MSK, 32'h0, q);
        settle();
        `CHK(irq, 1'b0)
        bus.xfer(1'b1, ADDR_IRQ_MSK, 32'h1, q);
        settle();
        `CHK(irq, 1'b1)
        bus.xfer(1'b1, ADDR_IRQ_ST, 32'h1, q);
        settle();
        `CHK(irq, 1'b0)
        repeat (8) @(posedge clk_i);
    endtask
    initial begin
        logic [3:0] b;
        logic [1:0] a;
        logic m;
        logic [7:0] s;
        void'($urandom(32'hCA42));
        for (int i = 0; i < 6; i++) begin
            b = (i == 0) ? 4'hF : 4'($urandom);
            a = (i == 0) ? 2'h3 : 2'($urandom);
            boot(b, 1'b1, a, 32'h19, 32'hFF, 0, 0);
            `CHK(node, exp_id(1'b0, 1'b1, b, a))
            `CHK(vend, 1'b1)
            `CHK(starts, 1)
        end
        bank <= ~b;
        settle();
        `CHK(node, exp_id(1'b0, 1'b1, b, a))
        for (int i = 0; i < 4; i++) begin
            s = (i == 0) ? 8'h01 : 8'(1 + $urandom % 255);
            boot(4'($urandom), 1'b1, 2'($urandom), 32'h18, {24'h0, s}, 0, 0);
            `CHK(node, s)
        end
        boot(b, 1'b0, a, 32'h18, 32'hFF, 0, 0);
        `CHK(node, ID_DEFAULT)
        `CHK(lss, 1'b1)
        `CHK(vend, 1'b0)
        `CHK(starts, 0)
        for (int i = 0; i < 4; i++) begin
            m = (i == 0) ? 1'b1 : 1'($urandom);
            b = (i == 0) ? 4'hF : 4'($urandom);
            a = (i == 0) ? 2'h3 : 2'($urandom);
            boot(b, m, a, 32'h1F, 32'hFF, 0, 0);
            `CHK(node, exp_id(1'b1, m, b, a))
            `CHK(alias_w, {8'h00, exp_id(1'b1, m, b, a)})
        end
        boot(b, m, a, 32'h1E, 32'hFF, 0, 0);
        `CHK(alias_w, ALIAS_NONE)
        boot(b, 1'b1, a, 32'h18, 32'hFF, 1, 0);
        `CHK(slave, 1'b1)
        `CHK(starts, 0)
        `CHK(node, exp_id(1'b0, 1'b1, b, a))
        bus.xfer(1'b0, ADDR_MERR, 32'h0, q);
        `CHK(q[MERR_SETUP_BIT], 1'b1)
        bus.xfer(1'b1, ADDR_MERR, 32'h1 << MERR_SETUP_BIT, q);
        bus.xfer(1'b0, ADDR_MERR, 32'h0, q);
        `CHK(q[MERR_SETUP_BIT], 1'b0)
        boot(b, 1'b1, a, 32'h19, 32'hFF, 0, 1);
        `CHK(starts, 0)
        `CHK(slave, 1'b1)
        boot(b, 1'b1, a, 32'h11, 32'hFF, 0, 0);
        `CHK(slave, 1'b1)
        bus.xfer(1'b0, 8'h40, 32'h0, q);
        `CHK(q, 32'h0)
        repeat (RESET_STORM_CNT) begin
            @(posedge clk_i);
            corrupt <= 1'b1;
            @(posedge clk_i);
            corrupt <= 1'b0;
        end
        settle();
        b[0] = rdy;
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            #1;
            if (rdy !== b[0]) n++;
            b[0] = rdy;
        end
        `CHK(n >= 4, 1'b1)
        `CHK(err, rdy)
        bus.xfer(1'b0, ADDR_IRQ_ST, 32'h0, q);
        `CHK(q[IRQ_RESET_STORM], 1'b1)
        conclude();
    end
endmodule
bind dsc_top dsc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .node_identifier_o(node_identifier_o),
    .vendor_can_protocol_mode_o(vendor_can_protocol_mode_o), .lss_inactive_o(lss_inactive_o),
    .station_alias_o(station_alias_o), .program_start_o(program_start_o), .slave_mode_o(slave_mode_o),
    .motor_supply_ok_i(motor_supply_ok_i), .ready_led_o(ready_led_o), .error_led_o(error_led_o));
